// ===== hdl/wfd_pkg.sv
// Constants, register map and field layout of the wake frame detector.
// Assumes a 100 MHz core clock and a byte-wide receive stream.
`default_nettype none
package wfd_pkg;
  // Directly addressed management registers
  localparam logic [4:0] OFS_MMD_CTRL = 5'h0D;
  localparam logic [4:0] OFS_MMD_DATA = 5'h0E;
  localparam logic [4:0] OFS_INT_TWO = 5'h13;
  // Extended register space
  localparam logic [15:0] EXT_CFG = 16'h04A0;
  localparam logic [15:0] EXT_STAT = 16'h04A1;
  localparam logic [15:0] EXT_STN0 = 16'h04A2;
  localparam logic [15:0] EXT_STN1 = 16'h04A3;
  localparam logic [15:0] EXT_STN2 = 16'h04A4;
  localparam logic [15:0] EXT_PWD0 = 16'h04A5;
  localparam logic [15:0] EXT_PWD1 = 16'h04A6;
  localparam logic [15:0] EXT_PWD2 = 16'h04A7;
  localparam logic [4:0] MMD_VENDOR = 5'h1F;
  localparam logic [1:0] FN_ADDR = 2'h0;
  localparam logic [1:0] FN_DATA = 2'h1;
  // Configuration and interrupt bit positions, configuration reset value
  localparam int CFG_EN = 0;
  localparam int CFG_BCAST = 1;
  localparam int CFG_PASS = 2;
  localparam int CFG_LEVEL = 3;
  localparam int CFG_GPIO = 4;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam int INT2_EN = 0;
  localparam int INT2_PEND = 8;
  // Frame layout and pattern
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [2:0] ADDR_LAST = 3'h5;
  localparam logic [3:0] REP_LAST = 4'hF;
  localparam logic [3:0] DA_LEN = 4'h6;
  localparam logic [3:0] HDR_LEN = 4'hC;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
  // Management frame
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [4:0] HEAD_LAST = 5'h0C;
  localparam logic [4:0] TA_LAST = 5'h01;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
endpackage
`default_nettype wire

// ===== hdl/wfd_reg_if.sv
// Register access carrier between the management slave and the core.
// Both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface wfd_reg_if;
  logic wr;
  logic rd;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport slave_side (output wr, output rd, output addr, output wdata,
    input rdata);
  modport regs_side (input wr, input rd, input addr, input wdata,
    output rdata);
endinterface
`default_nettype wire

// ===== hdl/wfd_mdio_slave.sv
// Serial management slave: decodes clause 22 frames into register strobes.
// Assumes mdc far below the core clock; mdc and mdio are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module wfd_mdio_slave
  import wfd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr_strap,
  // Register strobes
  wfd_reg_if.slave_side rif
);
  typedef enum logic [1:0] {
    M_IDLE = 2'b00, M_HEAD = 2'b01, M_TA = 2'b11, M_DATA = 2'b10
  } wfd_mstate_t;

  wfd_mstate_t mst_reg;
  logic [2:0] mdc_sync_reg;
  logic [1:0] mdio_sync_reg;
  logic [4:0] strap_s1_reg, strap_s2_reg, phy_addr_reg;
  logic [1:0] strap_cnt_reg;
  logic [4:0] cnt_reg;
  logic [15:0] sr_reg;
  logic is_read_reg;
  logic mdc_rise, bit_in;
  logic [12:0] head;

  // Two stage synchronisers, third mdc stage for the edge
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      mdc_sync_reg <= 3'h0;
      mdio_sync_reg <= 2'h3;
    end
    else
    begin
      mdc_sync_reg <= {mdc_sync_reg[1:0], mdc};
      mdio_sync_reg <= {mdio_sync_reg[0], mdio_in};
    end
  assign mdc_rise = mdc_sync_reg[1] & ~mdc_sync_reg[2];
  assign bit_in = mdio_sync_reg[1];
  assign head = {sr_reg[11:0], bit_in};

  // Address strap caught once after reset release
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      strap_s1_reg <= 5'h00;
      strap_s2_reg <= 5'h00;
      strap_cnt_reg <= 2'h0;
      phy_addr_reg <= 5'h00;
    end
    else
    begin
      strap_s1_reg <= phy_addr_strap;
      strap_s2_reg <= strap_s1_reg;
      if (strap_cnt_reg != STRAP_WAIT)
      begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
        phy_addr_reg <= strap_s2_reg;
      end
    end

  // Frame sequencer, shift register and pin drive
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      mst_reg <= M_IDLE;
      cnt_reg <= 5'h00;
      sr_reg <= 16'h0000;
      is_read_reg <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe <= 1'b0;
      rif.wr <= 1'b0;
      rif.rd <= 1'b0;
      rif.addr <= 5'h00;
      rif.wdata <= 16'h0000;
    end
    else
    begin
      rif.wr <= 1'b0;
      rif.rd <= 1'b0;
      if (mdc_rise)
        case (mst_reg)
          M_IDLE:
            if (!bit_in)
            begin
              mst_reg <= M_HEAD;
              cnt_reg <= 5'h00;
            end
          M_HEAD:
          begin
            sr_reg <= {sr_reg[14:0], bit_in};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == HEAD_LAST)
            begin
              cnt_reg <= 5'h00;
              rif.addr <= head[4:0];
              is_read_reg <= (head[11:10] == OP_READ);
              if (head[12] && head[9:5] == phy_addr_reg &&
                  (head[11:10] == OP_READ || head[11:10] == OP_WRITE))
              begin
                mst_reg <= M_TA;
                rif.rd <= (head[11:10] == OP_READ);
              end
              else
                mst_reg <= M_IDLE;
            end
          end
          M_TA:
          begin
            cnt_reg <= cnt_reg + 5'h01;
            if (is_read_reg && cnt_reg != TA_LAST)
            begin
              mdio_oe <= 1'b1;
              mdio_out <= 1'b0;
              sr_reg <= rif.rdata;
            end
            else if (is_read_reg)
            begin
              mdio_out <= sr_reg[15];
              sr_reg <= {sr_reg[14:0], 1'b0};
            end
            if (cnt_reg == TA_LAST)
            begin
              mst_reg <= M_DATA;
              cnt_reg <= 5'h00;
            end
          end
          M_DATA:
          begin
            cnt_reg <= cnt_reg + 5'h01;
            if (is_read_reg)
            begin
              mdio_out <= sr_reg[15];
              sr_reg <= {sr_reg[14:0], 1'b0};
            end
            else
              sr_reg <= {sr_reg[14:0], bit_in};
            if (cnt_reg == DATA_LAST)
            begin
              mst_reg <= M_IDLE;
              mdio_oe <= 1'b0;
              mdio_out <= 1'b1;
              rif.wr <= ~is_read_reg;
              rif.wdata <= {sr_reg[14:0], bit_in};
            end
          end
          default: mst_reg <= M_IDLE;
        endcase
    end
endmodule
`default_nettype wire

// ===== hdl/wake_frame_detector.sv
// Wake frame detector: pattern scan, frame check, registers and notify.
// Assumes rx bytes come from the receive path on clk; mdc/mdio are pins.
// Operation
// - On a qualifying wake frame notify by status bit, pin or interrupt flag.
// - Pin notification is a one cycle pulse or a level, by configuration.
// - Check each candidate frame's CRC; bad CRC suppresses wake and interrupt.
// - Matching works identically at 100 and 10 Mbps line speed.
// - When enabled, every frame addressed to this node is scanned.
// - Destination is own address or broadcast; valid source; good CRC.
// - Sixteen uninterrupted copies of the station address; any break fails.
// - With password enabled, the password must follow the last address copy.
// - The pattern may sit anywhere in the payload after the sync stream.
// - Sync stream is six consecutive bytes of all ones.
// - Detection is enabled and set up in the extended receive config register.
// - Results are reported in the extended receive status register.
// - Wake interrupt enable and pending sit in the second interrupt register.
// - Extended registers use vendor device select and the address/data pair.
// - Management frames address thirty-two sixteen bit registers directly.
`timescale 1ns/1ps
`default_nettype none
module wake_frame_detector
  import wfd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr_strap,
  // Receive byte stream
  input wire logic rx_frame_active,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  // Notification
  output logic wake_gpio,
  output logic wake_int
);
  typedef enum logic [1:0] {
    S_HUNT = 2'b00, S_ADDR = 2'b01, S_PASS = 2'b11, S_FOUND = 2'b10
  } wfd_state_t;

  logic [1:0] rst_pipe_reg;
  logic rst_n;
  wfd_reg_if rif ();

  logic [15:0] mmd_access_control_reg, mmd_address_data_reg;
  logic [15:0] wake_receive_config_reg;
  logic [15:0] stn_reg [3];
  logic [15:0] pwd_reg [3];
  logic stat_wake_reg, stat_crcerr_reg, stat_dest_reg;
  logic int_en_reg, int_pend_reg;
  logic [15:0] rdata_reg, ext_rdata, dir_rdata;
  logic dev_ok, ext_data_sel, ext_wr, ext_rd, stat_rd, int_rd;
  logic [47:0] stn_all, pwd_all;

  wfd_state_t st_reg;
  logic [2:0] ff_cnt_reg, pos_reg;
  logic [3:0] rep_reg, hdr_idx_reg;
  logic dest_own_reg, dest_bc_reg, src_ok_reg, active_d_reg;
  logic [31:0] crc_reg;
  logic frame_end, in_byte, crc_ok, dest_ok, wake_evt, crcbad_evt;

  // Byte picked out of a six byte field, first received in the low bits
  function automatic logic [7:0] pick_byte(input logic [47:0] v,
                                           input logic [2:0] i);
    pick_byte = v[{i, 3'b000} +: 8];
  endfunction

  // One byte of the reflected frame check sequence
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h000000, d};
    for (int k = 0; k < 8; k++)
      x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
    crc_step = x;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      rst_pipe_reg <= 2'h0;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  assign rst_n = rst_pipe_reg[1];

  wfd_mdio_slave u_mdio (
    .clk(clk),
    .rst_n(rst_n),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .phy_addr_strap(phy_addr_strap),
    .rif(rif)
  );

  // Indirect access decode
  assign stn_all = {stn_reg[2], stn_reg[1], stn_reg[0]};
  assign pwd_all = {pwd_reg[2], pwd_reg[1], pwd_reg[0]};
  assign dev_ok = (mmd_access_control_reg[4:0] == MMD_VENDOR);
  assign ext_data_sel = (rif.addr == OFS_MMD_DATA) && dev_ok &&
                        (mmd_access_control_reg[15:14] == FN_DATA);
  assign ext_wr = rif.wr && ext_data_sel;
  assign ext_rd = rif.rd && ext_data_sel;
  assign stat_rd = ext_rd && (mmd_address_data_reg == EXT_STAT);
  assign int_rd = rif.rd && (rif.addr == OFS_INT_TWO);

  // Control registers and indirect pointer
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      mmd_access_control_reg <= 16'h0000;
      mmd_address_data_reg <= 16'h0000;
      wake_receive_config_reg <= CFG_RESET;
      int_en_reg <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        stn_reg[i] <= 16'h0000;
        pwd_reg[i] <= 16'h0000;
      end
    end
    else if (rif.wr)
    begin
      if (rif.addr == OFS_MMD_CTRL)
        mmd_access_control_reg <= rif.wdata;
      if (rif.addr == OFS_MMD_DATA && dev_ok &&
          mmd_access_control_reg[15:14] == FN_ADDR)
        mmd_address_data_reg <= rif.wdata;
      if (rif.addr == OFS_INT_TWO)
        int_en_reg <= rif.wdata[INT2_EN];
      if (ext_wr)
        case (mmd_address_data_reg)
          EXT_CFG: wake_receive_config_reg <= rif.wdata;
          EXT_STN0: stn_reg[0] <= rif.wdata;
          EXT_STN1: stn_reg[1] <= rif.wdata;
          EXT_STN2: stn_reg[2] <= rif.wdata;
          EXT_PWD0: pwd_reg[0] <= rif.wdata;
          EXT_PWD1: pwd_reg[1] <= rif.wdata;
          EXT_PWD2: pwd_reg[2] <= rif.wdata;
          default: ;
        endcase
    end

  // Read data selection
  always_comb
  begin
    case (mmd_address_data_reg)
      EXT_CFG: ext_rdata = wake_receive_config_reg;
      EXT_STAT: ext_rdata = {13'h0000, stat_dest_reg, stat_crcerr_reg,
                             stat_wake_reg};
      EXT_STN0: ext_rdata = stn_reg[0];
      EXT_STN1: ext_rdata = stn_reg[1];
      EXT_STN2: ext_rdata = stn_reg[2];
      EXT_PWD0: ext_rdata = pwd_reg[0];
      EXT_PWD1: ext_rdata = pwd_reg[1];
      EXT_PWD2: ext_rdata = pwd_reg[2];
      default: ext_rdata = 16'h0000;
    endcase
    case (rif.addr)
      OFS_MMD_CTRL: dir_rdata = mmd_access_control_reg;
      OFS_MMD_DATA:
        if (!dev_ok)
          dir_rdata = 16'h0000;
        else if (mmd_access_control_reg[15:14] == FN_ADDR)
          dir_rdata = mmd_address_data_reg;
        else
          dir_rdata = ext_rdata;
      OFS_INT_TWO: dir_rdata = {7'h00, int_pend_reg, 7'h00, int_en_reg};
      default: dir_rdata = 16'h0000;
    endcase
  end

  // Read data latched on the read strobe
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rdata_reg <= 16'h0000;
    else if (rif.rd)
      rdata_reg <= dir_rdata;
  assign rif.rdata = rdata_reg;

  // Frame boundary and byte qualifier; the byte path is speed agnostic
  assign frame_end = active_d_reg & ~rx_frame_active;
  assign in_byte = rx_byte_valid & rx_frame_active;

  // Header position, destination and source checks, running CRC
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      active_d_reg <= 1'b0;
      hdr_idx_reg <= 4'h0;
      dest_own_reg <= 1'b1;
      dest_bc_reg <= 1'b1;
      src_ok_reg <= 1'b0;
      crc_reg <= CRC_INIT;
    end
    else
    begin
      active_d_reg <= rx_frame_active;
      if (frame_end)
      begin
        hdr_idx_reg <= 4'h0;
        dest_own_reg <= 1'b1;
        dest_bc_reg <= 1'b1;
        src_ok_reg <= 1'b0;
        crc_reg <= CRC_INIT;
      end
      else if (in_byte)
      begin
        crc_reg <= crc_step(crc_reg, rx_byte);
        if (hdr_idx_reg != HDR_LEN)
          hdr_idx_reg <= hdr_idx_reg + 4'h1;
        if (hdr_idx_reg < DA_LEN)
        begin
          if (rx_byte != pick_byte(stn_all, hdr_idx_reg[2:0]))
            dest_own_reg <= 1'b0;
          if (rx_byte != SYNC_BYTE)
            dest_bc_reg <= 1'b0;
        end
        if (hdr_idx_reg == DA_LEN)
          src_ok_reg <= ~rx_byte[0];
      end
    end

  // Pattern scan over the payload: sync, address copies, password
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      st_reg <= S_HUNT;
      ff_cnt_reg <= 3'h0;
      pos_reg <= 3'h0;
      rep_reg <= 4'h0;
    end
    else if (frame_end)
    begin
      st_reg <= S_HUNT;
      ff_cnt_reg <= 3'h0;
      pos_reg <= 3'h0;
      rep_reg <= 4'h0;
    end
    else if (in_byte && hdr_idx_reg == HDR_LEN)
      case (st_reg)
        S_HUNT:
          if (rx_byte == SYNC_BYTE)
          begin
            if (ff_cnt_reg != SYNC_LEN)
              ff_cnt_reg <= ff_cnt_reg + 3'h1;
          end
          else if (ff_cnt_reg == SYNC_LEN &&
                   rx_byte == pick_byte(stn_all, 3'h0))
          begin
            st_reg <= S_ADDR;
            pos_reg <= 3'h1;
            rep_reg <= 4'h0;
          end
          else
            ff_cnt_reg <= 3'h0;
        S_ADDR:
          if (rx_byte == pick_byte(stn_all, pos_reg))
          begin
            pos_reg <= (pos_reg == ADDR_LAST) ? 3'h0 : pos_reg + 3'h1;
            if (pos_reg == ADDR_LAST && rep_reg == REP_LAST)
              st_reg <= wake_receive_config_reg[CFG_PASS] ?
                        S_PASS : S_FOUND;
            else if (pos_reg == ADDR_LAST)
              rep_reg <= rep_reg + 4'h1;
          end
          else
          begin
            st_reg <= S_HUNT;
            ff_cnt_reg <= (rx_byte == SYNC_BYTE) ? 3'h1 : 3'h0;
          end
        S_PASS:
          if (rx_byte == pick_byte(pwd_all, pos_reg))
          begin
            pos_reg <= pos_reg + 3'h1;
            if (pos_reg == ADDR_LAST)
              st_reg <= S_FOUND;
          end
          else
          begin
            st_reg <= S_HUNT;
            pos_reg <= 3'h0;
            ff_cnt_reg <= (rx_byte == SYNC_BYTE) ? 3'h1 : 3'h0;
          end
        S_FOUND: st_reg <= S_FOUND;
        default: st_reg <= S_HUNT;
      endcase

  // Qualification at frame end
  assign crc_ok = (crc_reg == CRC_RESIDUE);
  assign dest_ok = dest_own_reg |
                   (wake_receive_config_reg[CFG_BCAST] & dest_bc_reg);
  assign wake_evt = frame_end & wake_receive_config_reg[CFG_EN] &
                    (st_reg == S_FOUND) & dest_ok & src_ok_reg &
                    crc_ok;
  assign crcbad_evt = frame_end & wake_receive_config_reg[CFG_EN] &
                      (st_reg == S_FOUND) & ~crc_ok;

  // Sticky wake and CRC status and pending flag, set wins over clear on read; destination status reloaded at each frame end
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      stat_wake_reg <= 1'b0;
      stat_crcerr_reg <= 1'b0;
      stat_dest_reg <= 1'b0;
      int_pend_reg <= 1'b0;
    end
    else
    begin
      stat_wake_reg <= wake_evt | (stat_wake_reg & ~stat_rd);
      stat_crcerr_reg <= crcbad_evt | (stat_crcerr_reg & ~stat_rd);
      if (frame_end)
        stat_dest_reg <= dest_ok;
      int_pend_reg <= wake_evt | (int_pend_reg & ~int_rd);
    end

  // Pin and interrupt outputs
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wake_gpio <= 1'b0;
      wake_int <= 1'b0;
    end
    else
    begin
      if (!wake_receive_config_reg[CFG_GPIO])
        wake_gpio <= 1'b0;
      else if (wake_receive_config_reg[CFG_LEVEL])
        wake_gpio <= wake_evt | (wake_gpio & ~stat_rd);
      else
        wake_gpio <= wake_evt;
      wake_int <= (wake_evt | (int_pend_reg & ~int_rd)) & int_en_reg;
    end

  // Checks on the running design
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_GPIO_PULSE: assert property (
    (wake_evt && wake_receive_config_reg[CFG_GPIO] &&
     !wake_receive_config_reg[CFG_LEVEL] && !rif.wr)
    |=> wake_gpio ##1 !wake_gpio)
    else $error("gpio pulse not one cycle");
  AST_GPIO_LEVEL: assert property (
    (wake_gpio && wake_receive_config_reg[CFG_LEVEL] &&
     wake_receive_config_reg[CFG_GPIO] && !stat_rd && !rif.wr)
    |=> wake_gpio)
    else $error("gpio level dropped without clear");
  AST_WAKE_CRC: assert property (
    $rose(stat_wake_reg) |-> $past(crc_reg) == CRC_RESIDUE)
    else $error("wake set on bad crc");
  AST_WAKE_AT_END: assert property (
    $rose(int_pend_reg) |-> $past(active_d_reg) && !$past(rx_frame_active))
    else $error("wake raised away from frame end");
  AST_WAKE_ENABLED: assert property (
    $rose(stat_wake_reg) |-> $past(wake_receive_config_reg[CFG_EN]))
    else $error("wake while disabled");
  AST_SYNC_BEFORE: assert property (
    (st_reg == S_ADDR && $past(st_reg) == S_HUNT)
    |-> $past(ff_cnt_reg) == SYNC_LEN)
    else $error("address run without six sync bytes");
  AST_ADDR_BREAK: assert property (
    (st_reg == S_ADDR && in_byte &&
     rx_byte != pick_byte(stn_all, pos_reg)) |=> st_reg == S_HUNT)
    else $error("broken address run kept");
  AST_PASS_GATE: assert property (
    (st_reg == S_FOUND && $past(st_reg) == S_ADDR)
    |-> !$past(wake_receive_config_reg[CFG_PASS]))
    else $error("password skipped");
  AST_INT_SOURCE: assert property (
    $rose(wake_int) |-> $past(wake_evt) || $past(int_pend_reg))
    else $error("interrupt without wake");
  AST_MMD_IGNORE: assert property (
    (rif.wr && rif.addr == OFS_MMD_DATA && !dev_ok)
    |=> $stable(wake_receive_config_reg) && $stable(mmd_address_data_reg))
    else $error("wrong device select accepted");

  COV_WAKE: cover property (wake_evt);
  COV_CRC_BAD: cover property (crcbad_evt);
  COV_PASSWORD: cover property (st_reg == S_PASS ##[1:8] st_reg == S_FOUND);
endmodule
`default_nettype wire

// ===== testbench/wfd_host_model.sv
// Management station model: clause 22 frames and extended access.
// Assumes mdio_wire is the resolved bus wire, pulled up when released.
`timescale 1ns/1ps
`default_nettype none
module wfd_host_model
  import wfd_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h03
)
(
  // Clock and pins
  input wire logic clk,
  input wire logic mdio_wire,
  output logic mdc,
  output logic mdio_drv
);
  // Bus idle at time zero, clock stopped
  initial
  begin
    mdc = 1'b0;
    mdio_drv = 1'b1;
  end
  // One frame; bits change in the low phase, sampled at mdc rise
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [33:0] f;
    f = {4'b1101, op, PHY_ADDR, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 33; i >= 0; i--)
    begin
      // Read releases the bus from turnaround on
      mdio_drv = (op == OP_READ && i < 18) ? 1'b1 : f[i];
      repeat (5) @(negedge clk);
      mdc = 1'b1;
      if (i < 16) rd[i] = mdio_wire;
      repeat (5) @(negedge clk);
      mdc = 1'b0;
    end
    mdio_drv = 1'b1;
  endtask
  // Extended register access through select and address/data pair
  task automatic ext_acc(input logic wr, input logic [15:0] a,
    input logic [15:0] d, output logic [15:0] rd);
    logic [15:0] x;
    xfer(OP_WRITE, OFS_MMD_CTRL, {11'h000, MMD_VENDOR}, x);
    xfer(OP_WRITE, OFS_MMD_DATA, a, x);
    xfer(OP_WRITE, OFS_MMD_CTRL, {FN_DATA, 9'h000, MMD_VENDOR}, x);
    xfer(wr ? OP_WRITE : OP_READ, OFS_MMD_DATA, d, rd);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Testbench: wake frames through the receive stream, checks via management.
// Assumes the station model above and a pulled-up management data wire.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wfd_pkg::*;
;
  typedef struct packed {
    logic en; logic bc; logic [2:0] ns; logic [4:0] nr;
    logic [1:0] pw; logic bad; logic gap; logic cfgp; logic lvl;
  } wfd_case_t;
  logic clk, reset_n, mdc, mdio_drv, rx_frame_active, rx_byte_valid;
  logic [7:0] rx_byte;
  logic mdio_out, mdio_oe, wake_gpio, wake_int, pat, wk;
  wire logic mdio_wire;
  logic [15:0] rd;
  wfd_case_t cs;
  int n_errors, num_checks, cnt;
  logic [7:0] sta [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
  logic [7:0] pwd [6] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F};
  // Own, bad fcs, 15 copies, 5 sync, broadcast slow, off, pwd ok, pwd bad
  wfd_case_t cases [8] = '{'{1, 0, 6, 16, 0, 0, 0, 0, 0},
    '{1, 0, 6, 16, 0, 1, 0, 0, 0}, '{1, 0, 6, 15, 0, 0, 0, 0, 0},
    '{1, 0, 5, 16, 0, 0, 0, 0, 0}, '{1, 1, 7, 16, 0, 0, 1, 0, 0},
    '{0, 0, 6, 16, 0, 0, 0, 0, 0}, '{1, 0, 6, 16, 1, 0, 0, 1, 1},
    '{1, 0, 6, 16, 2, 0, 0, 1, 1}};
  // Resolved bus wire with pull-up
  assign mdio_wire = mdio_oe ? mdio_out : mdio_drv;
  always #5 clk = ~clk;
  wake_frame_detector wake_frame_detector_i (.clk(clk), .reset_n(reset_n),
    .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .phy_addr_strap(5'h03), .rx_frame_active(rx_frame_active),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .wake_gpio(wake_gpio), .wake_int(wake_int));
  wfd_host_model wfd_host_model_i (.clk(clk), .mdio_wire(mdio_wire),
    .mdc(mdc), .mdio_drv(mdio_drv));
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Build frame with good or broken fcs, send it, count gpio highs
  task automatic send_case(input wfd_case_t c, output int n);
    logic [7:0] q [$];
    logic [31:0] crc;
    for (int i = 0; i < 6; i++) q.push_back(c.bc ? 8'hFF : sta[i]);
    for (int i = 0; i < 8; i++) q.push_back(i < 6 ? 8'(i + 2) : 8'h00);
    repeat (c.ns) q.push_back(8'hFF);
    repeat (c.nr) for (int j = 0; j < 6; j++) q.push_back(sta[j]);
    if (c.pw != 0)
      for (int j = 0; j < 6; j++)
        q.push_back((c.pw == 2 && j == 2) ? ~pwd[j] : pwd[j]);
    crc = CRC_INIT;
    foreach (q[k])
      for (int b = 0; b < 8; b++)
        crc = (crc >> 1) ^ ((crc[0] ^ q[k][b]) ? CRC_POLY : 32'h0);
    crc = ~crc ^ {31'h0, c.bad};
    for (int k = 0; k < 4; k++) q.push_back(crc[8*k+:8]);
    foreach (q[k])
    begin
      rx_frame_active = 1'b1;
      rx_byte = q[k];
      rx_byte_valid = 1'b1;
      @(negedge clk);
      if (c.gap)
      begin
        rx_byte_valid = 1'b0;
        repeat (3) @(negedge clk);
      end
    end
    rx_byte_valid = 1'b0;
    rx_frame_active = 1'b0;
    n = 0;
    repeat (6) @(negedge clk) if (wake_gpio === 1'b1) n++;
  endtask
  // Watchdog
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    give_verdict;
  end
  // Main sequence
  initial
  begin
    clk = 1'b0; reset_n = 1'b0; rx_frame_active = 1'b0;
    rx_byte_valid = 1'b0; rx_byte = 8'h00; n_errors = 0; num_checks = 0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (20) @(negedge clk);
    chk("idle_outputs", {mdio_oe, wake_gpio, wake_int, mdio_out},
      16'h0001);
    wfd_host_model_i.ext_acc(1'b0, EXT_CFG, 16'h0000, rd);
    chk("cfg_reset", rd, CFG_RESET);
    // Wrong device select: data access must read zero and write nothing
    wfd_host_model_i.xfer(OP_WRITE, OFS_MMD_CTRL, 16'h4003, rd);
    wfd_host_model_i.xfer(OP_WRITE, OFS_MMD_DATA, 16'h001F, rd);
    wfd_host_model_i.xfer(OP_READ, OFS_MMD_DATA, 16'h0000, rd);
    chk("wrong_device_read", rd, 16'h0000);
    wfd_host_model_i.xfer(OP_WRITE, OFS_MMD_CTRL, 16'h401F, rd);
    wfd_host_model_i.xfer(OP_READ, OFS_MMD_DATA, 16'h0000, rd);
    chk("wrong_device_write", rd, CFG_RESET);
    wfd_host_model_i.ext_acc(1'b0, 16'h04B0, 16'h0000, rd);
    chk("unmapped_ext", rd, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      wfd_host_model_i.ext_acc(1'b1, 16'(EXT_STN0 + i),
        {sta[2*i+1], sta[2*i]}, rd);
      wfd_host_model_i.ext_acc(1'b1, 16'(EXT_PWD0 + i),
        {pwd[2*i+1], pwd[2*i]}, rd);
    end
    wfd_host_model_i.ext_acc(1'b0, EXT_STN1, 16'h0000, rd);
    chk("station_word", rd, 16'h4433);
    wfd_host_model_i.xfer(OP_WRITE, OFS_INT_TWO, 16'h0001, rd);
    foreach (cases[c])
    begin
      cs = cases[c];
      wfd_host_model_i.ext_acc(1'b1, EXT_CFG,
        {11'h000, 1'b1, cs.lvl, cs.cfgp, 1'b1, cs.en}, rd);
      pat = cs.ns >= 6 && cs.nr == 16 && (!cs.cfgp || cs.pw == 1);
      wk = cs.en & pat & !cs.bad;
      send_case(cs, cnt);
      chk("gpio", cs.lvl ? 16'(cnt > 1) : 16'(cnt), 16'(wk));
      chk("wake_int", 16'(wake_int), 16'(wk));
      wfd_host_model_i.ext_acc(1'b0, EXT_STAT, 16'h0000, rd);
      chk("status", 16'(rd[2:0]),
        {13'h0000, 1'b1, cs.en & pat & cs.bad, wk});
      chk("gpio_after_read", 16'(wake_gpio), 16'h0000);
      wfd_host_model_i.xfer(OP_READ, OFS_INT_TWO, 16'h0000, rd);
      chk("int_two", rd & 16'h0101, {7'h00, wk, 8'h01});
      chk("int_cleared", 16'(wake_int), 16'h0000);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
